// [src/ldp_led_drive_pulse.sv]
// Purpose: LED drive configuration bank and Time Slot A pulse timer
// Assumes: Register port driven by serial-interface logic on clk; slot start from the sequencer on clk
// Notes:   Settings are sampled at each slot start taken while idle and held until the sequence ends
//
// Overview of operation
// - First LED edge-rate code at bits 6:4, 0 slowest, 7 fastest, resets zero.
// - First LED coarse current code at bits 3:0, 0 lowest, F highest, resets zero.
// - Peak target is coarse term times fine term times scale term for the first and second LED.
// - Second LED bit 13 selects full strength or low power; resets to one.
// - Second LED edge-rate code at bits 6:4, resets zero, 7 fastest.
// - Second LED coarse current code at bits 3:0, resets zero, F highest.
// - Fine register bits 15:11 hold third LED fine code, reset 0xC.
// - Fine register bits 10:6 hold second LED fine code, reset 0xC.
// - Fine register bits 4:0 hold first LED fine code, reset 0xC; bit 5 reserved.
// - Slot A pulse lasts width field (bits 12:8) microseconds, default 3.
// - Slot A pulse starts after offset field (bits 7:0) microseconds, default 0x20.
`timescale 1ns/10ps
`default_nettype none
`include "ldp_params.svh"

module ldp_led_drive_pulse
(
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  input  wire logic                      ce,
  input  wire ldp_pkg::ldp_reg_req_t     reg_req,
  output logic [15:0]                    reg_rdata,
  output logic                           reg_rvalid,
  input  wire logic                      slot_a_start,
  output logic                           slot_a_pulse,
  output logic                           slot_a_busy,
  output ldp_pkg::ldp_emitter_cfg_t      emitter_one_output,
  output ldp_pkg::ldp_emitter_cfg_t      emitter_two_output,
  output logic [4:0]                     emitter_three_output,
  output logic [25:0]                    emitter_one_peak,
  output logic [25:0]                    emitter_two_peak
);

  localparam logic [6:0] STEP_LAST = 7'(`LDP_STEP_CYCLES - 1);

  logic [15:0] led1_drive_ctrl;
  logic [15:0] led2_drive_ctrl;
  logic [15:0] led_fine_adjust;
  logic [15:0] slot_a_pulse_timing;
  logic [15:0] next_led1_drive_ctrl;
  logic [15:0] next_led2_drive_ctrl;
  logic [15:0] next_led_fine_adjust;
  logic [15:0] next_slot_a_pulse_timing;
  logic [15:0] next_reg_rdata;
  logic        next_reg_rvalid;

  ldp_pkg::ldp_state_t        state;
  ldp_pkg::ldp_state_t        next_state;
  logic [6:0]                 step_cnt;
  logic [6:0]                 next_step_cnt;
  logic [7:0]                 us_left;
  logic [7:0]                 next_us_left;
  logic [4:0]                 held_width;
  logic [4:0]                 next_held_width;
  logic [7:0]                 held_offset;
  logic [7:0]                 next_held_offset;
  logic                       next_slot_a_pulse;
  logic                       next_slot_a_busy;
  ldp_pkg::ldp_emitter_cfg_t  next_emitter_one_output;
  ldp_pkg::ldp_emitter_cfg_t  next_emitter_two_output;
  logic [4:0]                 next_emitter_three_output;
  logic [25:0]                next_emitter_one_peak;
  logic [25:0]                next_emitter_two_peak;
  ldp_pkg::ldp_emitter_cfg_t  cfg_one;
  ldp_pkg::ldp_emitter_cfg_t  cfg_two;
  logic                       launch;
  logic                       step_tick;

  // Drive word plus fine code into one emitter setting
  function automatic ldp_pkg::ldp_emitter_cfg_t emitter_cfg(input logic [15:0] drive, input logic [4:0] fine);
    ldp_pkg::ldp_emitter_cfg_t c;
    c.edge_rate = drive[`LDP_EDGE_MSB:`LDP_EDGE_LSB];
    c.coarse    = drive[`LDP_COARSE_MSB:`LDP_COARSE_LSB];
    c.strength  = drive[`LDP_STRENGTH_BIT];
    c.fine      = fine;
    return c;
  endfunction : emitter_cfg

  // Peak target, LSB 10 nA: (50.3+19.8c) * (0.74+0.022f) * (0.1+0.9s)
  function automatic logic [25:0] peak_target(input ldp_pkg::ldp_emitter_cfg_t c);
    logic [11:0] coarse_term;
    logic [10:0] fine_term;
    logic [3:0]  scale_term;
    coarse_term = `LDP_COARSE_BASE + 12'(12'(c.coarse) * `LDP_COARSE_STEP);
    fine_term   = `LDP_FINE_BASE + 11'(11'(c.fine) * `LDP_FINE_STEP);
    scale_term  = c.strength ? 4'(`LDP_SCALE_BASE + `LDP_SCALE_STEP) : `LDP_SCALE_BASE;
    return 26'(26'(coarse_term) * 26'(fine_term) * 26'(scale_term));
  endfunction : peak_target

  assign cfg_one   = emitter_cfg(led1_drive_ctrl, led_fine_adjust[`LDP_FINE1_MSB:`LDP_FINE1_LSB]);
  assign cfg_two   = emitter_cfg(led2_drive_ctrl, led_fine_adjust[`LDP_FINE2_MSB:`LDP_FINE2_LSB]);
  assign launch    = (state == ldp_pkg::LDP_IDLE) && slot_a_start;
  assign step_tick = (step_cnt == STEP_LAST);

  // Register bank; reserved bits are stored as written and read back
  always_comb
  begin
    next_led1_drive_ctrl     = led1_drive_ctrl;
    next_led2_drive_ctrl     = led2_drive_ctrl;
    next_led_fine_adjust     = led_fine_adjust;
    next_slot_a_pulse_timing = slot_a_pulse_timing;
    next_reg_rdata           = reg_rdata;
    next_reg_rvalid          = reg_req.rd;
    if (reg_req.wr)
    begin
      case (reg_req.addr)
        `LDP_ADDR_LED1_DRIVE: next_led1_drive_ctrl     = reg_req.wdata;
        `LDP_ADDR_LED2_DRIVE: next_led2_drive_ctrl     = reg_req.wdata;
        `LDP_ADDR_FINE_ADJ:   next_led_fine_adjust     = reg_req.wdata;
        `LDP_ADDR_SLOTA_TIME: next_slot_a_pulse_timing = reg_req.wdata;
        default:              ;
      endcase
    end
    if (reg_req.rd)
    begin
      case (reg_req.addr)
        `LDP_ADDR_LED1_DRIVE: next_reg_rdata = led1_drive_ctrl;
        `LDP_ADDR_LED2_DRIVE: next_reg_rdata = led2_drive_ctrl;
        `LDP_ADDR_FINE_ADJ:   next_reg_rdata = led_fine_adjust;
        `LDP_ADDR_SLOTA_TIME: next_reg_rdata = slot_a_pulse_timing;
        default:              next_reg_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      led1_drive_ctrl     <= `LDP_RST_LED1_DRIVE;
      led2_drive_ctrl     <= `LDP_RST_LED2_DRIVE;
      led_fine_adjust     <= `LDP_RST_FINE_ADJ;
      slot_a_pulse_timing <= `LDP_RST_SLOTA_TIME;
      reg_rdata           <= 16'h0000;
      reg_rvalid          <= 1'b0;
    end
    else if (ce)
    begin
      led1_drive_ctrl     <= next_led1_drive_ctrl;
      led2_drive_ctrl     <= next_led2_drive_ctrl;
      led_fine_adjust     <= next_led_fine_adjust;
      slot_a_pulse_timing <= next_slot_a_pulse_timing;
      reg_rdata           <= next_reg_rdata;
      reg_rvalid          <= next_reg_rvalid;
    end
  end

  // Pulse timer; a start while busy is ignored so a running sequence keeps its settings
  always_comb
  begin
    next_state                = state;
    next_step_cnt             = step_cnt;
    next_us_left              = us_left;
    next_held_width           = held_width;
    next_held_offset          = held_offset;
    next_slot_a_pulse         = slot_a_pulse;
    next_emitter_one_output   = emitter_one_output;
    next_emitter_two_output   = emitter_two_output;
    next_emitter_three_output = emitter_three_output;
    next_emitter_one_peak     = emitter_one_peak;
    next_emitter_two_peak     = emitter_two_peak;
    case (state)
      ldp_pkg::LDP_IDLE:
      begin
        next_step_cnt = 7'h00;
        if (launch)
        begin
          next_held_width           = slot_a_pulse_timing[`LDP_WIDTH_MSB:`LDP_WIDTH_LSB];
          next_held_offset          = slot_a_pulse_timing[`LDP_OFFSET_MSB:`LDP_OFFSET_LSB];
          next_emitter_one_output   = cfg_one;
          next_emitter_two_output   = cfg_two;
          next_emitter_three_output = led_fine_adjust[`LDP_FINE3_MSB:`LDP_FINE3_LSB];
          next_emitter_one_peak     = peak_target(cfg_one);
          next_emitter_two_peak     = peak_target(cfg_two);
          if (next_held_offset != 8'h00)
          begin
            next_state   = ldp_pkg::LDP_DELAY;
            next_us_left = next_held_offset;
          end
          else if (next_held_width != 5'h00)
          begin
            next_state        = ldp_pkg::LDP_DRIVE;
            next_us_left      = 8'(next_held_width);
            next_slot_a_pulse = 1'b1;
          end
        end
      end
      ldp_pkg::LDP_DELAY:
      begin
        next_step_cnt = step_tick ? 7'h00 : 7'(step_cnt + 7'h01);
        if (step_tick)
        begin
          next_us_left = 8'(us_left - 8'h01);
          if (us_left == 8'h01)
          begin
            if (held_width != 5'h00)
            begin
              next_state        = ldp_pkg::LDP_DRIVE;
              next_us_left      = 8'(held_width);
              next_slot_a_pulse = 1'b1;
            end
            else
            begin
              next_state = ldp_pkg::LDP_IDLE;
            end
          end
        end
      end
      ldp_pkg::LDP_DRIVE:
      begin
        next_step_cnt = step_tick ? 7'h00 : 7'(step_cnt + 7'h01);
        if (step_tick)
        begin
          next_us_left = 8'(us_left - 8'h01);
          if (us_left == 8'h01)
          begin
            next_state        = ldp_pkg::LDP_IDLE;
            next_slot_a_pulse = 1'b0;
          end
        end
      end
      default:
      begin
        next_state        = ldp_pkg::LDP_IDLE;
        next_slot_a_pulse = 1'b0;
      end
    endcase
    next_slot_a_busy = (next_state != ldp_pkg::LDP_IDLE);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                <= ldp_pkg::LDP_IDLE;
      step_cnt             <= 7'h00;
      us_left              <= 8'h00;
      held_width           <= 5'h00;
      held_offset          <= 8'h00;
      slot_a_pulse         <= 1'b0;
      slot_a_busy          <= 1'b0;
      emitter_one_output   <= '0;
      emitter_two_output   <= '0;
      emitter_three_output <= 5'h00;
      emitter_one_peak     <= 26'h000_0000;
      emitter_two_peak     <= 26'h000_0000;
    end
    else if (ce)
    begin
      state                <= next_state;
      step_cnt             <= next_step_cnt;
      us_left              <= next_us_left;
      held_width           <= next_held_width;
      held_offset          <= next_held_offset;
      slot_a_pulse         <= next_slot_a_pulse;
      slot_a_busy          <= next_slot_a_busy;
      emitter_one_output   <= next_emitter_one_output;
      emitter_two_output   <= next_emitter_two_output;
      emitter_three_output <= next_emitter_three_output;
      emitter_one_peak     <= next_emitter_one_peak;
      emitter_two_peak     <= next_emitter_two_peak;
    end
  end

  // Helper counters for the timing checks
  logic [15:0] since_launch;
  logic [11:0] pulse_len;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      since_launch <= 16'h0000;
      pulse_len    <= 12'h000;
    end
    else if (ce)
    begin
      since_launch <= launch ? 16'h0001 : 16'(since_launch + 16'h0001);
      pulse_len    <= slot_a_pulse ? 12'(pulse_len + 12'h001) : 12'h000;
    end
  end

  // Checks assume ce held high across the observed span
  sequence seq_launch;
    launch;
  endsequence
  sequence seq_write(logic [7:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence

  chk_edge_one_write: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_write(`LDP_ADDR_LED1_DRIVE) ##[1:8] seq_launch |=> emitter_one_output.edge_rate == $past(led1_drive_ctrl[6:4]))
    else $error("first emitter edge rate not taken from drive register");
  chk_coarse_one_read: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    reg_req.rd && reg_req.addr == `LDP_ADDR_LED1_DRIVE |=> reg_rvalid && reg_rdata[3:0] == $past(led1_drive_ctrl[3:0]))
    else $error("first emitter coarse readback wrong");
  chk_peak_formula: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_launch |=> emitter_one_peak == 26'((26'd503 + 26'd198 * emitter_one_output.coarse)
      * (26'd740 + 26'd22 * emitter_one_output.fine) * (emitter_one_output.strength ? 26'd10 : 26'd1)))
    else $error("first emitter peak target wrong");
  chk_strength_two: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_write(`LDP_ADDR_LED2_DRIVE) |=> led2_drive_ctrl[13] == $past(reg_req.wdata[13]))
    else $error("second emitter strength select not stored");
  chk_edge_two_apply: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_launch |=> emitter_two_output.edge_rate == $past(led2_drive_ctrl[6:4]))
    else $error("second emitter edge rate not applied");
  chk_coarse_two_apply: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_launch |=> emitter_two_output.coarse == $past(led2_drive_ctrl[3:0]))
    else $error("second emitter coarse code not applied");
  chk_fine_three: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_launch |=> emitter_three_output == $past(led_fine_adjust[15:11]))
    else $error("third emitter fine code not applied");
  chk_fine_two: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_launch |=> emitter_two_output.fine == $past(led_fine_adjust[10:6]))
    else $error("second emitter fine code not applied");
  chk_fine_one: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    seq_launch |=> emitter_one_output.fine == $past(led_fine_adjust[4:0]))
    else $error("first emitter fine code not applied");
  chk_pulse_width: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $fell(slot_a_pulse) |-> pulse_len == 12'(held_width * 12'd125))
    else $error("slot A pulse width wrong");
  chk_pulse_offset: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    $rose(slot_a_pulse) |-> since_launch == 16'(held_offset * 16'd125 + 16'd1))
    else $error("slot A pulse offset wrong");
  chk_held_settings: assert property (@(posedge clk) disable iff (!rst_n || !ce)
    slot_a_busy && $past(slot_a_busy) |-> $stable(emitter_one_output) && $stable(held_width))
    else $error("settings changed during a sequence");

endmodule : ldp_led_drive_pulse
`default_nettype wire

// [src/ldp_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the LED drive/pulse bank
// Assumes: 8-bit register index, 16-bit register words
// Notes:   Included by bare name; definitions only
`ifndef LDP_PARAMS_SVH
`define LDP_PARAMS_SVH

`define LDP_ADDR_LED1_DRIVE  8'h23
`define LDP_ADDR_LED2_DRIVE  8'h24
`define LDP_ADDR_FINE_ADJ    8'h25
`define LDP_ADDR_SLOTA_TIME  8'h30

`define LDP_RST_LED1_DRIVE   16'h3000
`define LDP_RST_LED2_DRIVE   16'h3000
`define LDP_RST_FINE_ADJ     16'h630C
`define LDP_RST_SLOTA_TIME   16'h0320

`define LDP_EDGE_MSB         6
`define LDP_EDGE_LSB         4
`define LDP_COARSE_MSB       3
`define LDP_COARSE_LSB       0
`define LDP_STRENGTH_BIT     13
`define LDP_FINE3_MSB        15
`define LDP_FINE3_LSB        11
`define LDP_FINE2_MSB        10
`define LDP_FINE2_LSB        6
`define LDP_FINE1_MSB        4
`define LDP_FINE1_LSB        0
`define LDP_WIDTH_MSB        12
`define LDP_WIDTH_LSB        8
`define LDP_OFFSET_MSB       7
`define LDP_OFFSET_LSB       0

// Peak target in fixed point: coarse in 0.1 mA, fine in 0.001, scale in 0.1
`define LDP_COARSE_BASE      12'h01F7
`define LDP_COARSE_STEP      12'h00C6
`define LDP_FINE_BASE        11'h02E4
`define LDP_FINE_STEP        11'h0016
`define LDP_SCALE_BASE       4'h1
`define LDP_SCALE_STEP       4'h9

`define LDP_STEP_NS          1000
`define LDP_CLK_NS           8
`define LDP_STEP_CYCLES      ((`LDP_STEP_NS) / (`LDP_CLK_NS))

`endif

// [src/ldp_pkg.sv]
// Purpose: Types shared by the LED drive/pulse bank
// Assumes: Constants live in ldp_params.svh
// Notes:   Nothing here is imported; users write ldp_pkg::name
package ldp_pkg;

  typedef struct packed {
    logic [2:0] edge_rate;
    logic [3:0] coarse;
    logic       strength;
    logic [4:0] fine;
  } ldp_emitter_cfg_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } ldp_reg_req_t;

  typedef enum logic [1:0] {
    LDP_IDLE  = 2'b00,
    LDP_DELAY = 2'b01,
    LDP_DRIVE = 2'b10
  } ldp_state_t;

endpackage : ldp_pkg

// [verification/ldp_host_model.sv]
// Purpose: Host side of the register port for the LED drive/pulse bank
// Assumes: Requests change at the falling edge and are taken at the next rising edge
// Notes:   Idle bus inverts the address and data it held; reads leave data alone, so idle after a read shows the last written word
`timescale 1ns/10ps
`default_nettype none
`include "ldp_params.svh"

module ldp_host_model
(
  input  wire logic                  clk,
  output var ldp_pkg::ldp_reg_req_t  reg_req,
  input  wire logic [15:0]           reg_rdata,
  input  wire logic                  reg_rvalid
);
  initial
  begin
    reg_req = '0;
  end

  // Reserved bits always carry their fixed values
  function automatic logic [15:0] fix_word(input logic [7:0] a, input logic [15:0] d);
    case (a)
      `LDP_ADDR_LED1_DRIVE, `LDP_ADDR_LED2_DRIVE: return (d & 16'h207F) | 16'h1000;
      `LDP_ADDR_FINE_ADJ:   return d & 16'hFFDF;
      `LDP_ADDR_SLOTA_TIME: return d & 16'h1FFF;
      default:              return d;
    endcase
  endfunction : fix_word

  task automatic idle();
    reg_req.wr = 1'b0;
    reg_req.rd = 1'b0;
    reg_req.addr = ~reg_req.addr;
    reg_req.wdata = ~reg_req.wdata;
  endtask : idle

  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_req.addr = a;
    reg_req.wdata = fix_word(a, d);
    reg_req.wr = 1'b1;
    @(negedge clk);
    idle();
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic v);
    @(negedge clk);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(negedge clk);
    idle();
    v = reg_rvalid;
    d = reg_rdata;
  endtask : read_reg
endmodule : ldp_host_model
`default_nettype wire

// [verification/tb_top.sv]
// Purpose: Self-checking bench for the LED drive/pulse bank
// Assumes: All register traffic goes through host_u
// Notes:   Slot timing expected at 125 cycles per microsecond step
`timescale 1ns/10ps
`default_nettype none
`include "ldp_params.svh"
`define TB_CHK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) \
    begin \
      num_errors++; \
      $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end

module tb_top;
  localparam int STEP  = `LDP_STEP_CYCLES;
  localparam int LIMIT = 5000;
  // Starts low so no false falling edge appears at time zero
  logic                      clk = 1'b0;
  logic                      rst_n;
  logic                      ce;
  logic                      slot_a_start;
  ldp_pkg::ldp_reg_req_t     reg_req;
  logic [15:0]               reg_rdata;
  logic                      reg_rvalid;
  logic                      slot_a_pulse;
  logic                      slot_a_busy;
  ldp_pkg::ldp_emitter_cfg_t em1;
  ldp_pkg::ldp_emitter_cfg_t em2;
  logic [4:0]                em3;
  logic [25:0]               pk1;
  logic [25:0]               pk2;
  int                        num_errors = 0;
  int                        checks = 0;
  int                        cycles = 0;

  ldp_led_drive_pulse dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .slot_a_start(slot_a_start), .slot_a_pulse(slot_a_pulse),
    .slot_a_busy(slot_a_busy), .emitter_one_output(em1), .emitter_two_output(em2),
    .emitter_three_output(em3), .emitter_one_peak(pk1), .emitter_two_peak(pk2));

  ldp_host_model host_u (.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // A hang counts as a mismatch
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      num_errors++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  function automatic logic [25:0] peak(input int c, input int f, input int s);
    return 26'((503 + 198 * c) * (740 + 22 * f) * (s != 0 ? 10 : 1));
  endfunction : peak

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic        v;
    host_u.read_reg(a, d, v);
    `TB_CHK(v, 1'b1)
    `TB_CHK(d, e)
  endtask : rd_chk

  task automatic launch();
    @(negedge clk);
    slot_a_start = 1'b1;
    @(negedge clk);
    slot_a_start = 1'b0;
  endtask : launch

  task automatic measure(input int off, input int wid);
    int rise;
    int hi;
    int bz;
    rise = -1;
    hi = 0;
    bz = 0;
    // Entered on the falling edge right after the start was taken, so sample first
    for (int n = 1; n <= (off + wid) * STEP + 5; n++)
    begin
      if (slot_a_pulse === 1'b1)
      begin
        hi++;
        if (rise < 0)
          rise = n;
      end
      if (slot_a_busy === 1'b1)
        bz++;
      @(negedge clk);
    end
    `TB_CHK(rise, 1 + off * STEP)
    `TB_CHK(hi, wid * STEP)
    `TB_CHK(bz, (off + wid) * STEP)
  endtask : measure

  task automatic t_reset();
    rd_chk(`LDP_ADDR_LED1_DRIVE, 16'h3000);
    rd_chk(`LDP_ADDR_LED2_DRIVE, 16'h3000);
    rd_chk(`LDP_ADDR_FINE_ADJ, 16'h630C);
    rd_chk(`LDP_ADDR_SLOTA_TIME, 16'h0320);
    host_u.write_reg(8'h26, 16'hFFFF);
    rd_chk(8'h26, 16'h0000);
    `TB_CHK(em1, 13'h0000)
    ce = 1'b0;
    host_u.write_reg(`LDP_ADDR_LED2_DRIVE, 16'h1045);
    ce = 1'b1;
    rd_chk(`LDP_ADDR_LED2_DRIVE, 16'h3000);
    host_u.write_reg(`LDP_ADDR_LED2_DRIVE, 16'hFFFF);
    rd_chk(`LDP_ADDR_LED2_DRIVE, 16'h307F);
    $display("test reset done");
  endtask : t_reset

  task automatic t_codes();
    logic [3:0] k;
    logic [3:0] kn;
    logic [4:0] f;
    logic [4:0] fn;
    host_u.write_reg(`LDP_ADDR_SLOTA_TIME, 16'h0000);
    for (int i = 0; i < 16; i++)
    begin
      k = 4'(i);
      kn = ~k;
      f = {k, k[0]};
      fn = ~f;
      host_u.write_reg(`LDP_ADDR_LED1_DRIVE, {9'h060, k[2:0], k});
      host_u.write_reg(`LDP_ADDR_LED2_DRIVE, {2'b00, k[0], 6'h20, kn[2:0], kn});
      host_u.write_reg(`LDP_ADDR_FINE_ADJ, {1'b0, k, fn, 1'b0, f});
      launch();
      @(negedge clk);
      `TB_CHK(em1, {k[2:0], k, 1'b1, f})
      `TB_CHK(em2, {kn[2:0], kn, k[0], fn})
      `TB_CHK(em3, {1'b0, k})
      `TB_CHK(pk1, peak(k, f, 1))
      `TB_CHK(pk2, peak(kn, fn, k[0]))
      `TB_CHK(slot_a_busy, 1'b0)
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_timing();
    host_u.write_reg(`LDP_ADDR_SLOTA_TIME, 16'h0101);
    host_u.write_reg(`LDP_ADDR_LED1_DRIVE, 16'h3012);
    launch();
    fork
      measure(1, 1);
      begin
        repeat (5) @(negedge clk);
        host_u.write_reg(`LDP_ADDR_LED1_DRIVE, 16'h3034);
        slot_a_start = 1'b1;
        @(negedge clk);
        slot_a_start = 1'b0;
      end
    join
    `TB_CHK(em1.coarse, 4'h2)
    host_u.write_reg(`LDP_ADDR_SLOTA_TIME, 16'h0200);
    launch();
    measure(0, 2);
    `TB_CHK(em1.coarse, 4'h4)
    `TB_CHK(em1.edge_rate, 3'h3)
    $display("test timing done");
  endtask : t_timing

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    slot_a_start = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_codes();
    t_timing();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
